// ==== logic/hole_pkg.sv ====
// Shared constants and types for the ISA hole forward decoder.
// Assumes APB with 32-bit data and a 24-bit ISA memory address.
package hole_pkg;

	// APB side.
	localparam int PADDR_W = 12;
	localparam int PDATA_W = 32;
	localparam int IDX_W = 10;

	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_REGION_EN = 10'h049;
	localparam logic [IDX_W-1:0] IDX_HOLE_BOTTOM = 10'h04A;
	localparam logic [IDX_W-1:0] IDX_HOLE_TOP = 10'h04B;
	localparam logic [IDX_W-1:0] IDX_PIC_ICW_BASE = 10'h04C;
	localparam int PIC_WORDS = 4;

	// Reset values.
	localparam logic [7:0] RST_REGION_EN = 8'h00;
	localparam logic [7:0] RST_HOLE_BOTTOM = 8'h00;
	localparam logic [7:0] RST_HOLE_TOP = 8'h00;

	// ISA address layout.
	localparam int CYC_ADDR_W = 24;
	localparam int HOLE_LSB = 16;
	localparam int REGION_LSB = 14;
	localparam int REGION_CNT = 2;

	// Lowest 64 KB block a hole may cover (1 MB).
	localparam logic [7:0] HOLE_FLOOR_BLK = 8'h10;
	// First 16 KB expansion region, C0000h, in 16 KB units.
	localparam logic [9:0] REGION_BASE_BLK = 10'h030;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b01,
		ST_ANSWER = 2'b10
	} apb_state_t;

endpackage : hole_pkg

// ==== logic/decode_if.sv ====
// Carrier between the decoder top and its address match unit.
// Assumes both ends sit on the same clock; the match is combinational.
`timescale 1ns/1ps
interface decode_if;
	import hole_pkg::*;

	logic [CYC_ADDR_W-1:0] addr;
	logic [7:0] bottom;
	logic [7:0] top;
	logic [REGION_CNT-1:0] region_en;
	logic hole_on;
	logic hole_hit;
	logic region_sel;
	logic region_fwd;

	modport ctrl
	(
		output addr,
		output bottom,
		output top,
		output region_en,
		input hole_on,
		input hole_hit,
		input region_sel,
		input region_fwd
	);

	modport match
	(
		input addr,
		input bottom,
		input top,
		input region_en,
		output hole_on,
		output hole_hit,
		output region_sel,
		output region_fwd
	);
endinterface : decode_if

// ==== logic/hole_match.sv ====
// Address match unit: hole compare and 16 KB expansion region select.
// Assumes its inputs are stable register and address values on one clock.
`timescale 1ns/1ps
module hole_match
(
	// Decode carrier.
	decode_if.match dif
);
	import hole_pkg::*;

	logic [7:0] blk;
	logic [REGION_CNT-1:0] sel;

	assign blk = dif.addr[CYC_ADDR_W-1:HOLE_LSB];

	// A bottom above the top switches the hole off.
	assign dif.hole_on = dif.bottom <= dif.top;

	// Inclusive of both boundary blocks, never below 1 MB; 24 bits stop at 16 MB.
	assign dif.hole_hit = dif.hole_on && (blk >= HOLE_FLOOR_BLK)
		&& (blk >= dif.bottom) && (blk <= dif.top);

	genvar g;
	generate
		for (g = 0; g < REGION_CNT; g++)
		begin : g_region
			localparam logic [9:0] BLK = REGION_BASE_BLK + 10'(g);
			assign sel[g] = dif.addr[CYC_ADDR_W-1:REGION_LSB] == BLK;
		end
	endgenerate

	assign dif.region_sel = |sel;
	assign dif.region_fwd = |(sel & dif.region_en);

endmodule : hole_match

// ==== logic/isa_hole_forward_decode.sv ====
// ISA master / DMA memory cycle forward decoder with its APB register file.
// Assumes APB master and cycle source share pclk; the PIC words come from
// interrupt controller logic on the same clock.
`timescale 1ns/1ps

module isa_hole_forward_decode
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,

	// APB slave.
	input wire logic [hole_pkg::PADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [hole_pkg::PDATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [hole_pkg::PDATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,

	// ISA master / DMA memory cycle in.
	input wire logic cyc_valid,
	input wire logic [hole_pkg::CYC_ADDR_W-1:0] cyc_addr,

	// Master PIC initialization words, word 0 first.
	input wire logic [hole_pkg::PIC_WORDS-1:0][7:0] pic_init_command_words,

	// Forward decision, one cycle after the cycle is offered.
	output logic fwd_valid,
	output logic fwd_to_pci,
	output logic fwd_hole_block,
	output logic fwd_region_block,
	output logic [hole_pkg::CYC_ADDR_W-1:0] fwd_addr,

	// Status.
	output logic hole_enabled
);
	import hole_pkg::*;

	typedef struct packed
	{
		apb_state_t st;
		logic pready;
		logic pslverr;
		logic [PDATA_W-1:0] prdata;
		logic [7:0] region_en;
		logic [7:0] bottom;
		logic [7:0] top;
		logic fwd_valid;
		logic fwd_to_pci;
		logic fwd_hole_block;
		logic fwd_region_block;
		logic [CYC_ADDR_W-1:0] fwd_addr;
		logic hole_enabled;
	} state_t;

	// Bottom and top both reset to zero, so the hole is on but lies below 1 MB.
	localparam state_t RST_STATE = '{
		st: ST_IDLE,
		pready: 1'b0,
		pslverr: 1'b0,
		prdata: 32'h0000_0000,
		region_en: RST_REGION_EN,
		bottom: RST_HOLE_BOTTOM,
		top: RST_HOLE_TOP,
		fwd_valid: 1'b0,
		fwd_to_pci: 1'b0,
		fwd_hole_block: 1'b0,
		fwd_region_block: 1'b0,
		fwd_addr: 24'h00_0000,
		hole_enabled: 1'b1
	};

	state_t s_r;
	state_t s_nxt;

	decode_if dif ();

	logic [IDX_W-1:0] idx;
	logic aligned;
	logic mapped;
	logic is_pic;
	logic [7:0] rd_byte;
	logic access;
	logic wr_ok;
	logic region_block;

	// Address match unit.
	hole_match u_match
	(
		.dif(dif)
	);

	assign dif.addr = cyc_addr;
	assign dif.bottom = s_r.bottom;
	assign dif.top = s_r.top;
	assign dif.region_en = s_r.region_en[REGION_CNT-1:0];

	// Register decode.
	// The index is the byte address over four; the low two bits must be zero.
	assign idx = paddr[PADDR_W-1:2];
	assign aligned = paddr[1:0] == 2'b00;
	assign is_pic = idx[IDX_W-1:2] == IDX_PIC_ICW_BASE[IDX_W-1:2];
	assign mapped = aligned && (is_pic || idx == IDX_REGION_EN
		|| idx == IDX_HOLE_BOTTOM || idx == IDX_HOLE_TOP);

	// Access phase of a transfer; the answer follows one wait state later.
	assign access = psel && penable;

	// Only byte lane 0 holds register data; the read-only PIC words take no write.
	assign wr_ok = access && pwrite && mapped && pstrb[0];

	// A cycle to an expansion region whose enable bit is clear stays off PCI.
	assign region_block = dif.region_sel && !dif.region_fwd;

	// Read mux; an unmapped index reads as zero.
	always_comb
	begin
		rd_byte = 8'h00;
		if (is_pic)
		begin
			rd_byte = pic_init_command_words[idx[1:0]];
		end
		else
		begin
			case (idx)
				IDX_REGION_EN: rd_byte = s_r.region_en;
				IDX_HOLE_BOTTOM: rd_byte = s_r.bottom;
				IDX_HOLE_TOP: rd_byte = s_r.top;
				default: rd_byte = 8'h00;
			endcase
		end
	end

	always_comb
	begin
		s_nxt = s_r;

		// APB: one wait state, then pready; the write lands on the pready edge.
		case (s_r.st)
			ST_IDLE:
			begin
				s_nxt.pready = 1'b0;
				// A transfer is taken at its first access-phase edge.
				if (access)
				begin
					s_nxt.st = ST_ANSWER;
					s_nxt.pready = 1'b1;
					s_nxt.pslverr = !mapped;
					s_nxt.prdata = (mapped && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
				end
			end
			ST_ANSWER:
			begin
				s_nxt.st = ST_IDLE;
				s_nxt.pready = 1'b0;
				s_nxt.pslverr = 1'b0;
				// The write lands on the edge at which the master samples pready.
				if (wr_ok)
				begin
					case (idx)
						IDX_REGION_EN: s_nxt.region_en = pwdata[7:0];
						IDX_HOLE_BOTTOM: s_nxt.bottom = pwdata[7:0];
						IDX_HOLE_TOP: s_nxt.top = pwdata[7:0];
						default: s_nxt.region_en = s_r.region_en;
					endcase
				end
			end
			default:
			begin
				s_nxt.st = ST_IDLE;
				s_nxt.pready = 1'b0;
				s_nxt.pslverr = 1'b0;
			end
		endcase

		// Forward decision, registered one cycle after the offer.
		s_nxt.fwd_valid = cyc_valid;
		s_nxt.fwd_addr = cyc_valid ? cyc_addr : s_r.fwd_addr;
		s_nxt.fwd_hole_block = cyc_valid && dif.hole_hit;
		s_nxt.fwd_region_block = cyc_valid && region_block;
		s_nxt.fwd_to_pci = cyc_valid && !dif.hole_hit
			&& !region_block;
		// Status follows the boundary registers one cycle late, like the decision.
		s_nxt.hole_enabled = dif.hole_on;
	end

	// Every register, outputs included, sits in s_r, so each output leaves a flip-flop.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_r <= RST_STATE;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// Read data holds until the next answer; pready and pslverr pulse for one cycle.
	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign fwd_valid = s_r.fwd_valid;
	assign fwd_to_pci = s_r.fwd_to_pci;
	assign fwd_hole_block = s_r.fwd_hole_block;
	assign fwd_region_block = s_r.fwd_region_block;
	assign fwd_addr = s_r.fwd_addr;
	assign hole_enabled = s_r.hole_enabled;

endmodule : isa_hole_forward_decode

// ==== dv/hole_chk.sv ====
// Port checks for the ISA hole forward decoder.
// Assumes one pclk domain with active-low presetn.
`timescale 1ns/1ps
module hole_chk
(
	// Clock, reset and APB handshake.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// Cycle path.
	input wire logic cyc_valid,
	input wire logic [hole_pkg::CYC_ADDR_W-1:0] cyc_addr,
	input wire logic fwd_valid,
	input wire logic fwd_to_pci,
	input wire logic fwd_hole_block,
	input wire logic fwd_region_block,
	input wire logic [hole_pkg::CYC_ADDR_W-1:0] fwd_addr,
	input wire logic hole_enabled
);
	import hole_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_wait; psel && penable && !pready; endsequence
	sequence s_low; cyc_valid && cyc_addr[23:16] < HOLE_FLOOR_BLK; endsequence
	property p_ans; s_wait |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("long ready");
	property p_fwd; cyc_valid |=> fwd_valid && fwd_addr == $past(cyc_addr); endproperty
	a_fwd: assert property (p_fwd) else $error("no decision");
	property p_hole; fwd_hole_block |-> !fwd_to_pci; endproperty
	a_hole: assert property (p_hole) else $error("hole forwarded");
	property p_dis; !hole_enabled |-> !fwd_hole_block; endproperty
	a_dis: assert property (p_dis) else $error("hole off blocks");
	property p_floor; s_low |=> !fwd_hole_block; endproperty
	a_floor: assert property (p_floor) else $error("below floor");
	property p_reg; cyc_valid && cyc_addr[23:15] != 9'h018 |=> !fwd_region_block; endproperty
	a_reg: assert property (p_reg) else $error("region off");
	property p_sum; fwd_valid |-> fwd_to_pci == !(fwd_hole_block || fwd_region_block); endproperty
	a_sum: assert property (p_sum) else $error("bad sum");
endmodule : hole_chk
bind isa_hole_forward_decode hole_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr),
	.fwd_valid(fwd_valid), .fwd_to_pci(fwd_to_pci), .fwd_hole_block(fwd_hole_block),
	.fwd_region_block(fwd_region_block), .fwd_addr(fwd_addr), .hole_enabled(hole_enabled));

// ==== dv/isa_cycle_src.sv ====
// ISA master and DMA cycle source standing in for the far side.
// Assumes pclk; a request held for one clock gives one memory cycle.
`timescale 1ns/1ps
module isa_cycle_src
(
	// Clock and request.
	input wire logic pclk,
	input wire logic req,
	input wire logic [23:0] req_addr,
	// Memory cycle out.
	output logic cyc_valid = '0,
	output logic [23:0] cyc_addr = '0
);
	// The idle address toggles so that a stale match cannot pass.
	always @(posedge pclk)
	begin
		cyc_valid <= req;
		cyc_addr <= req ? req_addr : ~cyc_addr;
	end
endmodule : isa_cycle_src

// ==== dv/test_isa_hole_forward_decode.sv ====
// Self-checking bench for the ISA hole forward decoder.
// Assumes the cycle source and the bound checker are compiled with it.
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_count++; \
	$display("ERROR %s exp %h got %h", n, e, s); end end
module test_isa_hole_forward_decode;
	import hole_pkg::*;
	logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, req = '0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic pready, pslverr, cyc_valid, fv, fp, fh, fr, hole_enabled, e;
	logic [23:0] cyc_addr, req_addr = '0, fa, a;
	logic [3:0][7:0] pic = '0;
	logic [7:0] b, t;
	integer seed = 32'hc217c6f6;
	int err_count = 0, compares = 0;
	always #4 pclk = ~pclk;
	isa_hole_forward_decode uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr),
		.pic_init_command_words(pic), .fwd_valid(fv), .fwd_to_pci(fp), .fwd_hole_block(fh),
		.fwd_region_block(fr), .fwd_addr(fa), .hole_enabled(hole_enabled));
	isa_cycle_src u_src (.pclk(pclk), .req(req), .req_addr(req_addr), .cyc_valid(cyc_valid),
		.cyc_addr(cyc_addr));
	function automatic logic [2:0] exp_fwd(input logic [7:0] lo, hi, input logic [23:0] ad,
		input logic [1:0] en);
		logic h, r;
		h = lo <= hi && ad[23:16] >= HOLE_FLOOR_BLK && ad[23:16] >= lo && ad[23:16] <= hi;
		r = ad[23:15] == REGION_BASE_BLK[9:1] && !en[ad[14]];
		return {!(h || r), h, r};
	endfunction : exp_fwd
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		psel <= '1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= '1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== '1);
		q = prdata;
		e = pslverr;
		psel <= '0;
		penable <= '0;
		@(posedge pclk);
	endtask : apb
	task automatic offer(input logic [23:0] ad, input logic [2:0] x);
		req <= '1;
		req_addr <= ad;
		@(posedge pclk);
		req <= '0;
		@(posedge pclk);
		@(negedge pclk);
		`CHK("fwd", {1'b1, x, ad}, {fv, fp, fh, fr, fa})
		@(posedge pclk);
	endtask : offer
	task automatic end_sim;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim
	initial
	begin
		#80000;
		err_count++;
		end_sim;
	end
	initial
	begin
		pic <= 32'($random(seed));
		repeat (16) @(posedge pclk);
		presetn <= '1;
		@(posedge pclk);
		apb('0, 12'h128, '0);
		`CHK("bottom", {24'h0, RST_HOLE_BOTTOM}, q)
		`CHK("hole_on", RST_HOLE_BOTTOM <= RST_HOLE_TOP, hole_enabled)
		apb('0, 12'h124, '0);
		`CHK("region", {24'h0, RST_REGION_EN}, q)
		apb('1, 12'h130, 32'hA5);
		for (int k = 0; k < PIC_WORDS; k++)
		begin
			apb('0, 12'(12'h130 + 4 * k), '0);
			`CHK("pic", {24'h0, pic[k]}, q)
		end
		apb('0, 12'h200, '0);
		`CHK("unmapped", 1'b1, e)
		$display("register test done");
		for (int i = 0; i < 16; i++)
		begin
			{b, t} = 16'($random(seed));
			if (b < HOLE_FLOOR_BLK)
				b = b + HOLE_FLOOR_BLK;
			if (t < HOLE_FLOOR_BLK)
				t = t + HOLE_FLOOR_BLK;
			case (i)
				0: {b, t} = 16'h2030;
				1: {b, t} = 16'h3020;
				2: {b, t} = 16'h0018;
				3: {b, t} = 16'h10FF;
			endcase
			apb('1, 12'h128, {24'h0, b});
			apb('1, 12'h12C, {24'h0, t});
			apb('1, 12'h124, 32'(i));
			apb('0, 12'h12C, '0);
			`CHK("top", {24'h0, t}, q)
			`CHK("top_err", 1'b0, e)
			`CHK("hole_on", b <= t, hole_enabled)
			for (int j = 0; j < 7; j++)
			begin
				a = 24'($random(seed));
				case (j)
					0: a[23:16] = b;
					1: a[23:16] = t;
					2: a[23:16] = b - 8'h1;
					3: a[23:16] = t + 8'h1;
					4: a[23:15] = 9'h018;
				endcase
				offer(a, exp_fwd(b, t, a, 2'(i)));
			end
		end
		$display("hole and region test done");
		end_sim;
	end
endmodule : test_isa_hole_forward_decode
